/* tone_framer_defs.svh */
// Timing, flag and packet constants for the tone-digit data link framer.
`ifndef TONE_FRAMER_DEFS_SVH
`define TONE_FRAMER_DEFS_SVH
`define CLK_FREQ_HZ        50000000
`define TONE_TIME_MS       100
`define PAUSE_TIME_MS      100
`define FRAME_GAP_TIME_MS  200
`define TONE_CYCLES        ((`CLK_FREQ_HZ / 1000) * `TONE_TIME_MS)
`define PAUSE_CYCLES       ((`CLK_FREQ_HZ / 1000) * `PAUSE_TIME_MS)
`define FRAME_GAP_CYCLES   ((`CLK_FREQ_HZ / 1000) * `FRAME_GAP_TIME_MS)
`define START_FLAG_DIGIT   4'h0
`define END_FLAG_DIGIT     4'hC
`define MAX_PAYLOAD_BYTES  15
`define VER0_BYTES         2
`define VER1_BYTES         15
`define VER1_HEADER_BYTES  5
`define VERSION_ZERO       2'h0
`define VERSION_ONE        2'h1
`define VERSION_MSB        7
`define VERSION_LSB        6
`endif

/* tone_framer_pkg.sv */
// State types of the tone-digit framer's transmitter and receiver.
package tone_framer_pkg;
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_GAP   = 5'h02,
    TX_TONE  = 5'h04,
    TX_PAUSE = 5'h08,
    TX_TAIL  = 5'h10
  } tx_state_t;
  typedef enum logic [3:0] {
    RX_HUNT  = 4'h1,
    RX_START = 4'h2,
    RX_BODY  = 4'h4,
    RX_END   = 4'h8
  } rx_state_t;
endpackage : tone_framer_pkg

/* tone_framer_if.sv */
// Bundle between the framer and its receive silence timer.
`timescale 1ns/10ps
`default_nettype none
interface silence_if;
  logic tone_present;
  logic digit_pulse;
  logic gap_pulse;
  modport timer (input tone_present, output digit_pulse, output gap_pulse);
  modport framer (output tone_present, input digit_pulse, input gap_pulse);
endinterface : silence_if
`default_nettype wire

/* silence_timer.sv */
// Classifies receive silences into symbol gaps and frame gaps.
`timescale 1ns/10ps
`default_nettype none
`include "tone_framer_defs.svh"
module silence_timer #(
  parameter int unsigned GAP_CYCLES = `FRAME_GAP_CYCLES
) (
  input  wire logic core_clk,   // System clock.
  input  wire logic rst,        // Asynchronous reset, active high.
  silence_if.timer  sil         // Tone level in, gap events out.
);
  logic [31:0] quiet_cnt_reg;
  logic        tone_d_reg;
  logic        gap_seen_reg;
  logic        gap_hit;
  assign gap_hit = (quiet_cnt_reg == GAP_CYCLES - 1) && !gap_seen_reg;
  // A falling tone marks the end of one digit.
  assign sil.digit_pulse = tone_d_reg && !sil.tone_present;
  // Silence of two symbol gaps or more is reported once as a frame gap.
  assign sil.gap_pulse = gap_hit && !sil.tone_present;
  // Counts quiet cycles; any tone restarts the count.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      quiet_cnt_reg <= 32'h0;
      tone_d_reg    <= 1'b0;
      gap_seen_reg  <= 1'b1;
    end else begin
      tone_d_reg <= sil.tone_present;
      if (sil.tone_present) begin
        quiet_cnt_reg <= 32'h0;
        gap_seen_reg  <= 1'b0;
      end else begin
        if (!gap_hit)
          quiet_cnt_reg <= quiet_cnt_reg + 32'h1;
        if (gap_hit)
          gap_seen_reg <= 1'b1;
      end
    end
  end
endmodule : silence_timer
`default_nettype wire

/* tone_framer.sv */
// Tone-digit data link framer: builds and checks gap-flag-payload frames.
//
// Notes on behaviour
// - Sixteen tone digits, one nibble each.
// - Send one nibble per 200 ms only.
// - 100 ms tone then 100 ms silence.
// - Detect digits while voice shares channel.
// - No acknowledgement, no retry, no setup.
// - Unique flags frame payload, no stuffing.
// - 200 ms silence precedes and follows frame.
// - Start flag is digit zero.
// - End flag is digit C.
// - Payload holds at most fifteen bytes.
// - Broken sequence discarded, search restarts.
// - Header version field; version zero supported.
// - Version zero packet is two bytes.
// - Version one packet is fifteen bytes.
// - Identification page carries unit identifier.
// - Received identification pages get time stamp.
`timescale 1ns/10ps
`default_nettype none
`include "tone_framer_defs.svh"
module tone_framer #(
  parameter int unsigned TONE_CYC   = `TONE_CYCLES,
  parameter int unsigned PAUSE_CYC  = `PAUSE_CYCLES,
  parameter int unsigned GAP_CYC    = `FRAME_GAP_CYCLES,
  parameter int unsigned MAX_BYTES  = `MAX_PAYLOAD_BYTES
) (
  input  wire logic       core_clk,      // System clock, 50 MHz.
  input  wire logic       rst,           // Asynchronous reset, active high.
  input  wire logic       tx_start,      // Pulse: send held packet.
  input  wire logic       tx_page,       // Pulse: send identification page.
  input  wire logic [7:0] tx_len,        // Bytes in packet, 1 to 15.
  input  wire logic [7:0] tx_byte,       // Packet byte at tx_index.
  output logic      [3:0] tx_index,      // Byte index the framer reads.
  input  wire logic [7:0] unit_id,       // Unit identifier for pages.
  output logic            tx_busy,       // Frame being sent.
  output logic            tone_on,       // Drive tone to transceiver.
  output logic      [3:0] tone_digit,    // Digit code to transmit.
  input  wire logic       tone_valid,    // Transceiver digit-present pin.
  input  wire logic [3:0] tone_code,     // Transceiver decoded digit pins.
  output logic            rx_valid,      // Pulse: received byte ready.
  output logic      [7:0] rx_byte,       // Received byte.
  output logic      [3:0] rx_byte_index, // Position of received byte.
  output logic            rx_done,       // Pulse: frame accepted.
  output logic            rx_drop,       // Pulse: frame discarded.
  output logic            rx_page,       // Pulse: identification page seen.
  output logic      [7:0] page_id,       // Second byte of the last frame received, page or not.
  output logic     [31:0] page_stamp,    // Arrival time of last page.
  output logic     [31:0] time_now       // Free running time counter.
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic       valid_s1_reg;
  logic       valid_s2_reg;
  logic [3:0] code_s1_reg;
  logic [3:0] code_s2_reg;
  // Transceiver pins pass two flops before use.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_s1_reg <= 1'b0;
      valid_s2_reg <= 1'b0;
      code_s1_reg  <= 4'h0;
      code_s2_reg  <= 4'h0;
    end else begin
      valid_s1_reg <= tone_valid;
      valid_s2_reg <= valid_s1_reg;
      code_s1_reg  <= tone_code;
      code_s2_reg  <= code_s1_reg;
    end
  end

  // ==========================================================
  // Transmitter
  // ==========================================================
  tone_framer_pkg::tx_state_t tx_state_reg;
  tone_framer_pkg::tx_state_t tx_state_next;
  logic [31:0] tx_cnt_reg;
  logic [4:0]  tx_nib_reg;   // Nibble slot: 0 start, 1..2n data, last end.
  logic [4:0]  tx_last_reg;
  logic        tx_id_reg;
  logic [7:0]  tx_cur_byte;
  logic [3:0]  tx_nibble;
  logic        tx_cnt_done;
  logic [31:0] tx_limit;
  logic [7:0]  tx_len_clip;
  // clip payload: never more than fifteen bytes.
  assign tx_len_clip = (tx_len > MAX_BYTES[7:0]) ? MAX_BYTES[7:0] :
                       ((tx_len == 8'h00) ? 8'h01 : tx_len);
  // identification page: version zero header then the unit identifier.
  assign tx_cur_byte = tx_id_reg ?
    ((tx_index == 4'h0) ? {`VERSION_ZERO, 6'h00} : unit_id) : tx_byte;
  // nibble order: slot odd sends high nibble, even sends low.
  assign tx_index  = 4'((tx_nib_reg - 5'h1) >> 1);
  assign tx_nibble = tx_nib_reg[0] ? tx_cur_byte[7:4] : tx_cur_byte[3:0];
  // flags: digit 0 opens, digit C closes, payload unescaped.
  assign tone_digit = (tx_nib_reg == 5'h0) ? `START_FLAG_DIGIT :
                      (tx_nib_reg == tx_last_reg) ? `END_FLAG_DIGIT :
                      tx_nibble;
  assign tone_on = (tx_state_reg == tone_framer_pkg::TX_TONE);
  assign tx_busy = (tx_state_reg != tone_framer_pkg::TX_IDLE);
  assign tx_limit = (tx_state_reg == tone_framer_pkg::TX_TONE) ? TONE_CYC :
                    (tx_state_reg == tone_framer_pkg::TX_PAUSE) ? PAUSE_CYC :
                    GAP_CYC;
  assign tx_cnt_done = (tx_cnt_reg == tx_limit - 1);
  // pacing: gap, then tone plus pause per nibble, then gap.
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      tone_framer_pkg::TX_IDLE: begin
        if (tx_start || tx_page)
          tx_state_next = tone_framer_pkg::TX_GAP;
      end
      tone_framer_pkg::TX_GAP: begin
        if (tx_cnt_done)
          tx_state_next = tone_framer_pkg::TX_TONE;
      end
      tone_framer_pkg::TX_TONE: begin
        if (tx_cnt_done)
          tx_state_next = tone_framer_pkg::TX_PAUSE;
      end
      tone_framer_pkg::TX_PAUSE: begin
        if (tx_cnt_done)
          tx_state_next = (tx_nib_reg == tx_last_reg) ?
            tone_framer_pkg::TX_TAIL : tone_framer_pkg::TX_TONE;
      end
      tone_framer_pkg::TX_TAIL: begin
        // no retry: frame is sent once and forgotten.
        if (tx_cnt_done)
          tx_state_next = tone_framer_pkg::TX_IDLE;
      end
      default: tx_state_next = tone_framer_pkg::TX_IDLE;
    endcase
  end
  // Holds state, cycle count and nibble slot of the frame being sent.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_state_reg <= tone_framer_pkg::TX_IDLE;
      tx_cnt_reg   <= 32'h0;
      tx_nib_reg   <= 5'h0;
      tx_last_reg  <= 5'h1;
      tx_id_reg    <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg   <= (tx_state_next != tx_state_reg) ? 32'h0
                                                      : tx_cnt_reg + 32'h1;
      if (tx_state_reg == tone_framer_pkg::TX_IDLE) begin
        tx_nib_reg  <= 5'h0;
        tx_id_reg   <= tx_page && !tx_start;
        tx_last_reg <= (tx_page && !tx_start) ?
          5'(2 * `VER0_BYTES + 1) : 5'({tx_len_clip[3:0], 1'b0} + 5'h1);
      end else if (tx_state_reg == tone_framer_pkg::TX_PAUSE && tx_cnt_done)
        tx_nib_reg <= tx_nib_reg + 5'h1;
    end
  end

  // ==========================================================
  // Receiver
  // ==========================================================
  silence_if sil ();
  // gap classing: digit pin ignores voice, long quiet is frame gap.
  assign sil.tone_present = valid_s2_reg;
  silence_timer #(.GAP_CYCLES(GAP_CYC)) u_silence (
    .core_clk (core_clk),
    .rst      (rst),
    .sil      (sil.timer)
  );
  tone_framer_pkg::rx_state_t rx_state_reg;
  logic [3:0]  rx_code_reg;
  logic [3:0]  rx_hi_reg;
  logic        rx_half_reg;
  logic [4:0]  rx_cnt_reg;
  logic [7:0]  rx_first_reg;
  logic [7:0]  rx_next_byte;
  logic [4:0]  rx_expect;
  logic        rx_len_ok;
  logic        rx_is_page;
  logic        rx_is_start;
  logic        rx_is_end;
  assign rx_next_byte = {rx_hi_reg, rx_code_reg};
  assign rx_is_start = (rx_code_reg == `START_FLAG_DIGIT);
  assign rx_is_end   = (rx_code_reg == `END_FLAG_DIGIT);
  // length by version: zero is two bytes, one is fifteen.
  assign rx_expect =
    (rx_first_reg[`VERSION_MSB:`VERSION_LSB] == `VERSION_ZERO) ?
    5'(`VER0_BYTES) :
    (rx_first_reg[`VERSION_MSB:`VERSION_LSB] == `VERSION_ONE) ?
    5'(`VER1_BYTES) : 5'h1F;
  assign rx_len_ok = !rx_half_reg && (rx_cnt_reg == rx_expect);
  // version check: only version zero frames are pages.
  assign rx_is_page =
    (rx_first_reg[`VERSION_MSB:`VERSION_LSB] == `VERSION_ZERO);
  // Free running time base for page stamps.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      time_now <= 32'h0;
    else
      time_now <= time_now + 32'h1;
  end
  // digit capture: latch the four-bit code while tone is present.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      rx_code_reg <= 4'h0;
    else if (valid_s2_reg)
      rx_code_reg <= tone_code_s2();
  end
  function automatic logic [3:0] tone_code_s2();
    return code_s2_reg;
  endfunction : tone_code_s2
  // frame hunt: sequence gap, start, payload, end, gap, else discard.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg  <= tone_framer_pkg::RX_HUNT;
      rx_hi_reg     <= 4'h0;
      rx_half_reg   <= 1'b0;
      rx_cnt_reg    <= 5'h0;
      rx_first_reg  <= 8'h00;
      rx_valid      <= 1'b0;
      rx_byte       <= 8'h00;
      rx_byte_index <= 4'h0;
      rx_done       <= 1'b0;
      rx_drop       <= 1'b0;
      rx_page       <= 1'b0;
      page_id       <= 8'h00;
      page_stamp    <= 32'h0;
    end else begin
      rx_valid <= 1'b0;
      rx_done  <= 1'b0;
      rx_drop  <= 1'b0;
      rx_page  <= 1'b0;
      case (rx_state_reg)
        tone_framer_pkg::RX_HUNT: begin
          if (sil.gap_pulse)
            rx_state_reg <= tone_framer_pkg::RX_START;
        end
        tone_framer_pkg::RX_START: begin
          rx_half_reg <= 1'b0;
          rx_cnt_reg  <= 5'h0;
          // start detect: digit zero after a gap opens a frame.
          if (sil.digit_pulse)
            rx_state_reg <= rx_is_start ? tone_framer_pkg::RX_BODY
                                        : tone_framer_pkg::RX_HUNT;
        end
        tone_framer_pkg::RX_BODY: begin
          if (sil.gap_pulse) begin
            rx_drop      <= 1'b1;
            rx_state_reg <= tone_framer_pkg::RX_START;
          end else if (sil.digit_pulse) begin
            // end detect: C at the version's length closes payload.
            if (rx_is_end && !rx_half_reg && rx_cnt_reg == rx_expect)
              rx_state_reg <= tone_framer_pkg::RX_END;
            else if (!rx_half_reg) begin
              rx_hi_reg   <= rx_code_reg;
              rx_half_reg <= 1'b1;
            end else if (rx_cnt_reg == 5'(MAX_BYTES)) begin
              // overflow: sixteenth byte discards the frame.
              rx_drop      <= 1'b1;
              rx_state_reg <= tone_framer_pkg::RX_HUNT;
            end else begin
              rx_half_reg   <= 1'b0;
              rx_cnt_reg    <= rx_cnt_reg + 5'h1;
              rx_valid      <= 1'b1;
              rx_byte       <= rx_next_byte;
              rx_byte_index <= rx_cnt_reg[3:0];
              if (rx_cnt_reg == 5'h0)
                rx_first_reg <= rx_next_byte;
              if (rx_cnt_reg == 5'h1)
                page_id <= rx_next_byte;
            end
          end
        end
        tone_framer_pkg::RX_END: begin
          if (sil.digit_pulse) begin
            rx_drop      <= 1'b1;
            rx_state_reg <= tone_framer_pkg::RX_HUNT;
          end else if (sil.gap_pulse) begin
            rx_state_reg <= tone_framer_pkg::RX_START;
            rx_done      <= rx_len_ok;
            rx_drop      <= !rx_len_ok;
            // page stamp: record arrival time of a page.
            if (rx_len_ok && rx_is_page) begin
              rx_page    <= 1'b1;
              page_stamp <= time_now;
            end
          end
        end
        default: rx_state_reg <= tone_framer_pkg::RX_HUNT;
      endcase
    end
  end
endmodule : tone_framer
`default_nettype wire

/* tone_framer_properties.sv */
// Concurrent checks on the tone framer's transmit and receive ports.
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checker
module tone_framer_checker #(
  parameter int unsigned TONE_CYC  = 20,
  parameter int unsigned PAUSE_CYC = TONE_CYC, // Pause equals tone length.
  parameter int unsigned GAP_CYC   = 40
) (
  input wire logic       core_clk,   // System clock.
  input wire logic       rst,        // Reset, active high.
  input wire logic       tx_start,   // Send request.
  input wire logic       tx_page,    // Page request.
  input wire logic       tx_busy,    // Frame in progress.
  input wire logic       tone_on,    // Tone emitted.
  input wire logic [3:0] tone_digit, // Digit emitted.
  input wire logic       rx_done,    // Frame accepted.
  input wire logic       rx_drop,    // Frame dropped.
  input wire logic       rx_page     // Page seen.
);
  logic [31:0] on_run_reg;
  logic [31:0] off_run_reg;
  logic        first_reg;
  logic [3:0]  last_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Measures tone and silence runs and keeps the frame's first-tone flag and last digit.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      on_run_reg  <= '0;
      off_run_reg <= '0;
      first_reg   <= 1'b1;
      last_reg    <= 4'h0;
    end else begin
      on_run_reg  <= tone_on ? on_run_reg + 1 : '0;
      off_run_reg <= tone_on ? '0 : off_run_reg + 1;
      first_reg   <= tone_on ? 1'b0 : (tx_busy ? first_reg : 1'b1);
      last_reg    <= tone_on ? tone_digit : last_reg;
    end
  end
  tone_len_a: assert property ($fell(tone_on) |-> on_run_reg == TONE_CYC)
    else $error("Tone length wrong.");
  pause_len_a: assert property ($rose(tone_on) |->
    off_run_reg >= (first_reg ? GAP_CYC : PAUSE_CYC))
    else $error("Silence before tone too short.");
  tone_busy_a: assert property (tone_on |-> tx_busy)
    else $error("Tone outside a frame.");
  busy_start_a: assert property (!tx_busy && (tx_start || tx_page)
    |=> tx_busy) else $error("Request not taken.");
  lead_gap_a: assert property ($rose(tx_busy) |-> (!tone_on)[*8])
    else $error("Tone too soon after start.");
  start_flag_a: assert property ($rose(tone_on) && first_reg
    |-> tone_digit == 4'h0) else $error("First digit not zero.");
  end_flag_a: assert property ($fell(tx_busy) |-> last_reg == 4'hC
    && off_run_reg >= GAP_CYC) else $error("Frame end malformed.");
  rx_pulse_a: assert property (rx_done || rx_drop |=> !rx_done && !rx_drop)
    else $error("Receive result longer than one cycle.");
  rx_excl_a: assert property (!(rx_done && rx_drop))
    else $error("Frame both kept and dropped.");
  page_done_a: assert property (rx_page |-> rx_done)
    else $error("Page without accepted frame.");
endmodule : tone_framer_checker
bind tone_framer tone_framer_checker #(
  .TONE_CYC(TONE_CYC), .GAP_CYC(GAP_CYC)
) tone_framer_checker_inst (
  .core_clk(core_clk), .rst(rst), .tx_start(tx_start), .tx_page(tx_page),
  .tx_busy(tx_busy), .tone_on(tone_on), .tone_digit(tone_digit),
  .rx_done(rx_done), .rx_drop(rx_drop), .rx_page(rx_page)
);
`default_nettype wire

/* tone_line_model.sv */
// Behavioural tone transceiver facing the framer's tone pins.
`timescale 1ns/10ps
`default_nettype none
// ==========
// Transceiver model
module tone_line_model #(
  parameter int unsigned TONE_CYC  = 20,
  parameter int unsigned PAUSE_CYC = 20
) (
  input  wire logic       core_clk,   // System clock.
  input  wire logic       tone_on,    // Tone from framer.
  input  wire logic [3:0] tone_digit, // Digit from framer.
  output var  logic       tone_valid, // Digit present.
  output var  logic [3:0] tone_code   // Decoded digit.
);
  logic [3:0] tx_seen[$];
  logic       on_last_reg;
  initial begin
    tone_valid  = 1'b0;
    tone_code   = 4'hF;
    on_last_reg = 1'b0;
  end
  // each new tone's digit is logged once in tx_seen.
  always @(posedge core_clk) begin
    if (tone_on && !on_last_reg) begin
      tx_seen.push_back(tone_digit);
    end
    on_last_reg <= tone_on;
  end
  // tone then pause; the code lines stop showing the digit after it.
  task automatic play(input logic [3:0] d);
    @(negedge core_clk);
    tone_valid = 1'b1;
    tone_code  = d;
    repeat (TONE_CYC) @(negedge core_clk);
    tone_valid = 1'b0;
    tone_code  = ~d;
    repeat (PAUSE_CYC - 1) @(negedge core_clk);
  endtask : play
  task automatic quiet(input int unsigned n);
    repeat (n) @(negedge core_clk);
  endtask : quiet
endmodule : tone_line_model
`default_nettype wire

/* test_tone_framer.sv */
// Self-checking bench for the tone framer.
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench
module test_tone_framer;
  localparam int unsigned GAP_N = 40;
  logic        core_clk, rst, tx_start, tx_page, tx_busy, tone_on;
  logic        tone_valid, rx_valid, rx_done, rx_drop, rx_page;
  logic [7:0]  tx_len, unit_id, rx_byte, page_id;
  logic [3:0]  tx_index, tone_digit, tone_code, rx_byte_index;
  logic [31:0] page_stamp, time_now;
  wire  [7:0]  tx_byte;
  logic [7:0]  tx_mem [16];
  logic [7:0]  rx_q[$];
  logic [7:0]  frame_q[$];
  int          err_total, check_count, n_done, n_drop, n_page;
  assign tx_byte = tx_mem[tx_index];
  tone_framer #(.TONE_CYC(20), .PAUSE_CYC(20), .GAP_CYC(GAP_N))
    tone_framer_inst (
    .core_clk(core_clk), .rst(rst), .tx_start(tx_start), .tx_page(tx_page),
    .tx_len(tx_len), .tx_byte(tx_byte), .tx_index(tx_index),
    .unit_id(unit_id), .tx_busy(tx_busy), .tone_on(tone_on),
    .tone_digit(tone_digit), .tone_valid(tone_valid),
    .tone_code(tone_code), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_byte_index(rx_byte_index), .rx_done(rx_done), .rx_drop(rx_drop),
    .rx_page(rx_page), .page_id(page_id), .page_stamp(page_stamp),
    .time_now(time_now));
  tone_line_model tone_line_model_inst (
    .core_clk(core_clk), .tone_on(tone_on), .tone_digit(tone_digit),
    .tone_valid(tone_valid), .tone_code(tone_code));
  // Free running clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Collects received bytes and frame outcomes.
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      check(rx_byte_index, rx_q.size());
      rx_q.push_back(rx_byte);
    end
    if (rx_done === 1'b1) n_done++;
    if (rx_drop === 1'b1) n_drop++;
    if (rx_page === 1'b1) n_page++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Sends frame_q, tries a refused restart midway, waits for the end.
  task automatic send(input logic page, input logic [7:0] len);
    tone_line_model_inst.tx_seen.delete();
    // A page must not come from the packet store, so it keeps old bytes.
    if (!page) foreach (frame_q[i]) tx_mem[i] = frame_q[i];
    @(negedge core_clk);
    tx_start = !page;
    tx_page  = page;
    tx_len   = len;
    @(negedge core_clk);
    tx_start = 1'b0;
    tx_page  = 1'b0;
    check(tx_busy, 1'b1);
    repeat (100) @(negedge core_clk);
    tx_start = 1'b1;
    @(negedge core_clk);
    tx_start = 1'b0;
    for (int i = 0; i < 3000 && tx_busy !== 1'b0; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    check(tx_busy, 1'b0);
  endtask : send
  // Compares sent digits with flag, nibbles high first, flag.
  task automatic check_tx;
    logic [3:0] exp[$];
    exp.push_back(4'h0);
    foreach (frame_q[i]) begin
      exp.push_back(frame_q[i][7:4]);
      exp.push_back(frame_q[i][3:0]);
    end
    exp.push_back(4'hC);
    check(tone_line_model_inst.tx_seen.size(), exp.size());
    foreach (exp[i]) check(tone_line_model_inst.tx_seen[i], exp[i]);
  endtask : check_tx
  // Plays a stray digit, a gap, then a frame from frame_q.
  task automatic rx_frame(input logic [3:0] first, input logic close);
    rx_q.delete();
    n_done = 0;
    n_drop = 0;
    n_page = 0;
    tone_line_model_inst.play(4'h1);
    tone_line_model_inst.quiet(GAP_N + 20);
    tone_line_model_inst.play(first);
    foreach (frame_q[i]) begin
      tone_line_model_inst.play(frame_q[i][7:4]);
      tone_line_model_inst.play(frame_q[i][3:0]);
    end
    if (close) tone_line_model_inst.play(4'hC);
    tone_line_model_inst.quiet(GAP_N + 20);
  endtask : rx_frame
  task automatic test_tx;
    frame_q = {8'h3C, 8'hA5};
    send(1'b0, 8'h02);
    check_tx();
    unit_id = 8'h9B;
    frame_q = {8'h00, 8'h9B};
    send(1'b1, 8'h05);
    check_tx();
    frame_q.delete();
    for (int i = 0; i < 15; i++) frame_q.push_back(8'(8'h4C + i));
    tx_mem[15] = 8'hEE;
    send(1'b0, 8'h20);
    check_tx();
    $display("test_tx finished");
  endtask : test_tx
  task automatic test_rx_good;
    frame_q = {8'h00, 8'h5A};
    rx_frame(4'h0, 1'b1);
    check(rx_q.size(), 2);
    foreach (frame_q[i]) check(rx_q[i], frame_q[i]);
    check(n_done, 1);
    check(n_page, 1);
    check(page_id, 8'h5A);
    check(page_stamp != 0 && page_stamp <= time_now, 1'b1);
    frame_q.delete();
    for (int i = 0; i < 15; i++)
      frame_q.push_back(8'(i == 0 ? 8'h40 : i * 17));
    rx_frame(4'h0, 1'b1);
    check(rx_q.size(), 15);
    check(n_done, 1);
    check(n_page, 0);
    $display("test_rx_good finished");
  endtask : test_rx_good
  task automatic test_rx_bad;
    frame_q = {8'h00, 8'h5A, 8'h11};
    rx_frame(4'h0, 1'b1);
    check(n_drop, 1);
    check(n_done, 0);
    frame_q = {8'h00, 8'h5A};
    rx_frame(4'h0, 1'b0);
    check(n_drop, 1);
    check(n_done, 0);
    rx_frame(4'h5, 1'b1);
    check(n_done, 0);
    $display("test_rx_bad finished");
  endtask : test_rx_bad
  // Main sequence.
  initial begin
    rst         = 1'b1;
    tx_start    = 1'b0;
    tx_page     = 1'b0;
    tx_len      = 8'h00;
    unit_id     = 8'h00;
    err_total   = 0;
    check_count = 0;
    foreach (tx_mem[i]) tx_mem[i] = 8'h00;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    test_tx();
    test_rx_good();
    test_rx_bad();
    report_and_stop();
  end
  // Watchdog against a hang.
  initial begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end
endmodule : test_tone_framer
`default_nettype wire
